// ==== rtl/spk_regs.sv ====
// sprite plane colour key and surface register bank with double buffering
`timescale 1ns/1ps
module spk_regs #(
    parameter int PHYS_PAGE_W = 24
) (
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    // register access port
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [spk_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [spk_pkg::DATA_W-1:0]    reg_wdata,
    output logic      [spk_pkg::DATA_W-1:0]    reg_rdata,
    output logic                               reg_rvalid,
    // update points
    input  wire logic                          vblank_start,
    input  wire logic                          pipe_enabled,
    // control from the sprite control register
    input  wire logic                          tiled_surface,
    input  wire logic                          src_key_enable,
    input  wire logic                          dst_key_enable,
    input  wire logic [31:0]                   linear_surface_offset,
    // pixels to compare
    input  wire logic [23:0]                   sprite_pixel,
    input  wire logic [23:0]                   primary_pixel,
    // translation table
    output logic      [spk_pkg::F_SURF_W-1:0]  gtt_page_index,
    input  wire logic [PHYS_PAGE_W-1:0]        gtt_phys_page,
    // live values for the plane
    output logic      [11:0]                   live_width_m1,
    output logic      [11:0]                   live_height_m1,
    output logic      [PHYS_PAGE_W+11:0]       phys_surface_base,
    output logic      [11:0]                   pan_x,
    output logic      [11:0]                   pan_y,
    output logic      [31:0]                   pan_linear,
    output logic                               size_armed,
    output logic                               src_key_hit,
    output logic                               dst_key_hit
);
    import spk_pkg::*;

    // ------------------------------------------------------------------
    // pending copies written by software, the live copies and the arm flag
    // ------------------------------------------------------------------
    logic [31:0] pend_size;
    logic [31:0] pend_kmin;
    logic [31:0] pend_kmask;
    logic [31:0] pend_surf;
    logic [31:0] pend_kmax;
    logic [31:0] pend_tile;
    logic [31:0] live_size;
    logic [31:0] live_kmin;
    logic [31:0] live_kmask;
    logic [31:0] live_surf;
    logic [31:0] live_kmax;
    logic [31:0] live_tile;
    logic        armed;
    logic        next_armed;

    // ------------------------------------------------------------------
    // write decode and masking of reserved bits
    // ------------------------------------------------------------------
    wire wr_size  = reg_wr && (reg_addr == OFS_SPRITE_SIZE);
    wire wr_kmin  = reg_wr && (reg_addr == OFS_KEY_MIN);
    wire wr_kmask = reg_wr && (reg_addr == OFS_KEY_MASK);
    wire wr_surf  = reg_wr && (reg_addr == OFS_SURFACE_BASE);
    wire wr_kmax  = reg_wr && (reg_addr == OFS_KEY_MAX);
    wire wr_tile  = reg_wr && (reg_addr == OFS_TILED_OFFSET);

    // reserved bits never reach the pending copies, so they always read back as zero
    wire [31:0] wval_size  = reg_wdata & WMASK_SIZE;
    wire [31:0] wval_kmin  = reg_wdata & WMASK_KEY_VAL;
    wire [31:0] wval_kmask = reg_wdata & WMASK_KEY_MASK;
    wire [31:0] wval_surf  = reg_wdata & WMASK_SURFACE;
    wire [31:0] wval_kmax  = reg_wdata & WMASK_KEY_VAL;
    wire [31:0] wval_tile  = reg_wdata & WMASK_TILED;

    // a disabled pipe takes the key and surface values at once; size still waits for a surface write to arm it
    wire update_point = vblank_start || !pipe_enabled;

    // a flip written in the update cycle keeps the arm for the next point
    assign next_armed = wr_surf || (armed && !update_point);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_size  <= RST_VALUE;
            pend_kmin  <= RST_VALUE;
            pend_kmask <= RST_VALUE;
            pend_surf  <= RST_VALUE;
            pend_kmax  <= RST_VALUE;
            pend_tile  <= RST_VALUE;
        end else begin
            if (wr_size)  pend_size  <= wval_size;
            if (wr_kmin)  pend_kmin  <= wval_kmin;
            if (wr_kmask) pend_kmask <= wval_kmask;
            if (wr_surf)  pend_surf  <= wval_surf;
            if (wr_kmax)  pend_kmax  <= wval_kmax;
            if (wr_tile)  pend_tile  <= wval_tile;
        end
    end

    // ------------------------------------------------------------------
    // double buffer load
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            armed     <= 1'b0;
            live_size <= RST_VALUE;
        end else begin
            armed <= next_armed;
            if (update_point && armed) live_size <= pend_size;
        end
    end

    // key and surface copies follow every update point, armed or not
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            live_kmin  <= RST_VALUE;
            live_kmask <= RST_VALUE;
            live_surf  <= RST_VALUE;
            live_kmax  <= RST_VALUE;
            live_tile  <= RST_VALUE;
        end else if (update_point) begin
            live_kmin  <= pend_kmin;
            live_kmask <= pend_kmask;
            live_surf  <= pend_surf;
            live_kmax  <= pend_kmax;
            live_tile  <= pend_tile;
        end
    end

    // ------------------------------------------------------------------
    // readback of the software view
    // ------------------------------------------------------------------
    // reads show the pending copy, so software sees its write before the flip lands
    wire [31:0] rd_mux =
        (reg_addr == OFS_SPRITE_SIZE)  ? pend_size  :
        (reg_addr == OFS_KEY_MIN)      ? pend_kmin  :
        (reg_addr == OFS_KEY_MASK)     ? pend_kmask :
        (reg_addr == OFS_SURFACE_BASE) ? pend_surf  :
        (reg_addr == OFS_KEY_MAX)      ? pend_kmax  :
        (reg_addr == OFS_TILED_OFFSET) ? pend_tile  : RST_VALUE;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata  <= RST_VALUE;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) reg_rdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // colour key compare
    // ------------------------------------------------------------------
    logic [2:0] ch_ok;
    logic [2:0] ch_en;
    // range enables sit above the destination masks in the same register
    assign ch_en = {live_kmask[F_SRC_EN_HI], live_kmask[F_SRC_EN_MID], live_kmask[F_SRC_EN_LO]};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_chan
            wire [7:0] px  = sprite_pixel[g*F_CH_W +: F_CH_W];
            wire [7:0] lo  = live_kmin[g*F_CH_W +: F_CH_W];
            wire [7:0] hi  = live_kmax[g*F_CH_W +: F_CH_W];
            // a channel left out of the check always passes
            assign ch_ok[g] = !ch_en[g] || ((px >= lo) && (px <= hi));
        end
    endgenerate

    // only masked bits can fail the match
    wire [23:0] dst_diff = (primary_pixel ^ live_kmin[23:0]) & live_kmask[23:0];
    // both enables at once is illegal; destination would not be trusted then
    wire src_hit_w = src_key_enable && (&ch_ok);
    wire dst_hit_w = dst_key_enable && !src_key_enable && (dst_diff == 24'h000000);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            src_key_hit <= 1'b0;
            dst_key_hit <= 1'b0;
        end else begin
            src_key_hit <= src_hit_w;
            dst_key_hit <= dst_hit_w;
        end
    end

    // ------------------------------------------------------------------
    // surface address and panning
    // ------------------------------------------------------------------
    assign gtt_page_index = live_surf[F_SURF_LSB +: F_SURF_W];

    logic [PHYS_PAGE_W+11:0] next_phys_base;
    logic [11:0]             next_pan_x;
    logic [11:0]             next_pan_y;
    logic [31:0]             next_pan_linear;

    // the two panning sources never mix: the one not in use reads as zero
    assign next_phys_base  = {gtt_phys_page, 12'h000};
    assign next_pan_x      = tiled_surface ? live_tile[F_XY_LO_LSB +: F_XY_W] : 12'h000;
    assign next_pan_y      = tiled_surface ? live_tile[F_XY_HI_LSB +: F_XY_W] : 12'h000;
    assign next_pan_linear = tiled_surface ? 32'h00000000 : linear_surface_offset;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phys_surface_base <= '0;
            pan_x             <= 12'h000;
            pan_y             <= 12'h000;
            pan_linear        <= 32'h00000000;
        end else begin
            phys_surface_base <= next_phys_base;
            pan_x             <= next_pan_x;
            pan_y             <= next_pan_y;
            pan_linear        <= next_pan_linear;
        end
    end

    assign live_width_m1  = live_size[F_XY_LO_LSB +: F_XY_W];
    assign live_height_m1 = live_size[F_XY_HI_LSB +: F_XY_W];
    assign size_armed     = armed;
endmodule : spk_regs

// ==== rtl/spk_pkg.sv ====
// constants for the sprite plane key and surface register bank
package spk_pkg;
    localparam int          ADDR_W            = 20;
    localparam int          DATA_W            = 32;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [19:0] OFS_SPRITE_SIZE   = 20'h73190;
    localparam logic [19:0] OFS_KEY_MIN       = 20'h73194;
    localparam logic [19:0] OFS_KEY_MASK      = 20'h73198;
    localparam logic [19:0] OFS_SURFACE_BASE  = 20'h7319C;
    localparam logic [19:0] OFS_KEY_MAX       = 20'h731A0;
    localparam logic [19:0] OFS_TILED_OFFSET  = 20'h731A4;

    // ------------------------------------------------------------------
    // reset values and writable bits
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_VALUE         = 32'h00000000;
    localparam logic [31:0] WMASK_SIZE        = 32'h0FFF0FFF;
    localparam logic [31:0] WMASK_KEY_VAL     = 32'h00FFFFFF;
    localparam logic [31:0] WMASK_KEY_MASK    = 32'h07FFFFFF;
    localparam logic [31:0] WMASK_SURFACE     = 32'hFFFFF000;
    localparam logic [31:0] WMASK_TILED       = 32'h0FFF0FFF;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          F_XY_LO_LSB       = 0;
    localparam int          F_XY_HI_LSB       = 16;
    localparam int          F_XY_W            = 12;
    localparam int          F_CH_HI_LSB       = 16;
    localparam int          F_CH_MID_LSB      = 8;
    localparam int          F_CH_LO_LSB       = 0;
    localparam int          F_CH_W            = 8;
    localparam int          F_SRC_EN_HI       = 26;
    localparam int          F_SRC_EN_MID      = 25;
    localparam int          F_SRC_EN_LO       = 24;
    localparam int          F_SURF_LSB        = 12;
    localparam int          F_SURF_W          = 20;
endpackage : spk_pkg

// ==== test/spk_regs_assertions.sv ====
// concurrent checks on the ports of the sprite key and surface register bank
`timescale 1ns/1ps
module spk_regs_assertions
    import spk_pkg::*;
#(
    parameter int PHYS_PAGE_W = 24
) (
    input wire logic                     sys_clk,
    input wire logic                     sys_rst,
    input wire logic                     reg_wr,
    input wire logic                     reg_rd,
    input wire logic [ADDR_W-1:0]        reg_addr,
    input wire logic [DATA_W-1:0]        reg_rdata,
    input wire logic                     reg_rvalid,
    input wire logic                     vblank_start,
    input wire logic                     pipe_enabled,
    input wire logic                     tiled_surface,
    input wire logic                     src_key_enable,
    input wire logic                     dst_key_enable,
    input wire logic [31:0]              linear_surface_offset,
    input wire logic [F_SURF_W-1:0]      gtt_page_index,
    input wire logic [PHYS_PAGE_W-1:0]   gtt_phys_page,
    input wire logic [PHYS_PAGE_W+11:0]  phys_surface_base,
    input wire logic [11:0]              pan_x,
    input wire logic [11:0]              pan_y,
    input wire logic [31:0]              pan_linear,
    input wire logic                     size_armed,
    input wire logic                     src_key_hit,
    input wire logic                     dst_key_hit
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_surf_wr;
        reg_wr && reg_addr == OFS_SURFACE_BASE;
    endsequence
    sequence s_rd(logic [ADDR_W-1:0] a);
        reg_rd && reg_addr == a;
    endsequence
    property p_arm; s_surf_wr |=> size_armed; endproperty
    property p_disarm; (vblank_start && !reg_wr) |=> !size_armed; endproperty
    property p_hold; (pipe_enabled && !vblank_start) |=> $stable(gtt_page_index); endproperty
    property p_gtt; 1'b1 |=> phys_surface_base == {$past(gtt_phys_page), 12'h000}; endproperty
    property p_surf_rsv; s_rd(OFS_SURFACE_BASE) |=> reg_rvalid && reg_rdata[11:0] == 12'h000;
    endproperty
    property p_size_rsv; s_rd(OFS_SPRITE_SIZE) |=> (reg_rdata & ~WMASK_SIZE) == 32'h0; endproperty
    property p_max_rsv; s_rd(OFS_KEY_MAX) |=> reg_rdata[31:24] == 8'h00; endproperty
    property p_linear;
        !tiled_surface |=> pan_x == 12'h0 && pan_linear == $past(linear_surface_offset);
    endproperty
    property p_src_off; !src_key_enable |=> !src_key_hit; endproperty
    property p_dst_off; (!dst_key_enable || src_key_enable) |=> !dst_key_hit; endproperty
    a_arm: assert property (p_arm) else $error("surface write did not arm size");
    a_disarm: assert property (p_disarm) else $error("arm flag kept after update");
    a_hold: assert property (p_hold) else $error("live surface moved off update");
    a_gtt: assert property (p_gtt) else $error("physical base not from table");
    a_surf_rsv: assert property (p_surf_rsv) else $error("surface low bits not zero");
    a_size_rsv: assert property (p_size_rsv) else $error("size reserved bits set");
    a_max_rsv: assert property (p_max_rsv) else $error("key max reserved bits set");
    a_linear: assert property (p_linear) else $error("linear pan wrong");
    a_src_off: assert property (p_src_off) else $error("source hit while off");
    a_dst_off: assert property (p_dst_off) else $error("dest hit while off");
endmodule : spk_regs_assertions

bind spk_regs spk_regs_assertions #(.PHYS_PAGE_W(PHYS_PAGE_W)) i_spk_regs_assertions (
    .sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_rdata, .reg_rvalid, .vblank_start,
    .pipe_enabled, .tiled_surface, .src_key_enable, .dst_key_enable, .linear_surface_offset,
    .gtt_page_index, .gtt_phys_page, .phys_surface_base, .pan_x, .pan_y, .pan_linear,
    .size_armed, .src_key_hit, .dst_key_hit);

// ==== test/tb.sv ====
// self-checking bench for the sprite key and surface register bank
`timescale 1ns/1ps
module tb;
    import spk_pkg::*;
    logic        sys_clk, sys_rst, reg_wr, reg_rd, reg_rvalid, vblank_start, pipe_enabled;
    logic        tiled_surface, src_key_enable, dst_key_enable, size_armed, src_hit, dst_hit;
    logic [19:0] reg_addr, gtt_page_index;
    logic [31:0] reg_wdata, reg_rdata, linear_surface_offset, pan_linear;
    logic [23:0] sprite_pixel, primary_pixel, gtt_phys_page;
    logic [11:0] width_m1, height_m1, pan_x, pan_y;
    logic [35:0] phys_surface_base;
    int          err_total = 0;
    int          checked = 0;
    int          cyc = 0;
    // the translation table answers at once with a fixed page frame tag on top
    assign gtt_phys_page = {4'hA, gtt_page_index};
    spk_regs #(.PHYS_PAGE_W(24)) i_spk_regs (.sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_rvalid, .vblank_start, .pipe_enabled, .tiled_surface,
        .src_key_enable, .dst_key_enable, .linear_surface_offset, .sprite_pixel, .primary_pixel,
        .gtt_page_index, .gtt_phys_page, .live_width_m1(width_m1), .live_height_m1(height_m1),
        .phys_surface_base, .pan_x, .pan_y, .pan_linear, .size_armed,
        .src_key_hit(src_hit), .dst_key_hit(dst_hit));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task summarize;
        if (err_total == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            summarize();
        end
    end
    task chk(input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task tick;
        @(posedge sys_clk);
        #1;
    endtask : tick
    task wr(input logic [19:0] a, input logic [31:0] d);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask : wr
    task rd(input logic [19:0] a, input logic [31:0] exp);
        reg_rd   = 1'b1;
        reg_addr = a;
        tick();
        reg_rd = 1'b0;
        chk(reg_rvalid, 1'b1);
        chk(reg_rdata, exp);
        // an idle edge keeps a following read from dropping and raising the strobe at once
        tick();
    endtask : rd
    task vb;
        vblank_start = 1'b1;
        tick();
        vblank_start = 1'b0;
        tick();
    endtask : vb
    task t_regs;
        logic [19:0] adr [6];
        logic [31:0] msk [6];
        adr = '{OFS_SPRITE_SIZE, OFS_KEY_MIN, OFS_KEY_MASK, OFS_SURFACE_BASE, OFS_KEY_MAX,
                OFS_TILED_OFFSET};
        msk = '{WMASK_SIZE, WMASK_KEY_VAL, WMASK_KEY_MASK, WMASK_SURFACE, WMASK_KEY_VAL,
                WMASK_TILED};
        for (int i = 0; i < 6; i++) begin
            rd(adr[i], RST_VALUE);
            wr(adr[i], 32'hFFFFFFFF);
            rd(adr[i], msk[i]);
        end
        wr(20'h731A8, 32'hFFFFFFFF);
        rd(20'h731A8, 32'h00000000);
        for (int i = 0; i < 6; i++) wr(adr[i], 32'h00000000);
        vb();
    endtask : t_regs
    task t_buf;
        wr(OFS_SPRITE_SIZE, 32'h00AB00CD);
        vb();
        chk(width_m1, 12'h000);
        wr(OFS_SURFACE_BASE, 32'h12345ABC);
        chk(size_armed, 1'b1);
        chk(gtt_page_index, 20'h00000);
        vb();
        chk({height_m1, width_m1}, 24'h0AB0CD);
        chk(gtt_page_index, 20'h12345);
        chk(phys_surface_base, 36'hA12345000);
        pipe_enabled = 1'b0;
        wr(OFS_SURFACE_BASE, 32'hABCDE000);
        chk(gtt_page_index, 20'hABCDE);
        pipe_enabled = 1'b1;
    endtask : t_buf
    task t_keys;
        wr(OFS_KEY_MIN, 32'h00102030);
        wr(OFS_KEY_MAX, 32'h00405060);
        wr(OFS_KEY_MASK, 32'h07000000);
        vb();
        src_key_enable = 1'b1;
        sprite_pixel   = 24'h304050;
        tick();
        chk(src_hit, 1'b1);
        sprite_pixel = 24'h304061;
        tick();
        chk(src_hit, 1'b0);
        wr(OFS_KEY_MASK, 32'h06000000);
        vb();
        chk(src_hit, 1'b1);
        src_key_enable = 1'b0;
        dst_key_enable = 1'b1;
        wr(OFS_KEY_MIN, 32'h0000AA00);
        wr(OFS_KEY_MASK, 32'h0000F000);
        vb();
        primary_pixel = 24'h33A5FF;
        tick();
        chk(dst_hit, 1'b1);
        primary_pixel = 24'h00B500;
        tick();
        chk(dst_hit, 1'b0);
        dst_key_enable = 1'b0;
    endtask : t_keys
    task t_pan;
        wr(OFS_TILED_OFFSET, 32'h00050007);
        vb();
        tiled_surface = 1'b1;
        tick();
        chk({pan_y, pan_x}, 24'h005007);
        chk(pan_linear, 32'h0);
        tiled_surface         = 1'b0;
        linear_surface_offset = 32'hDEADBEEF;
        tick();
        chk(pan_linear, 32'hDEADBEEF);
        chk(pan_x, 12'h000);
    endtask : t_pan
    initial begin
        sys_rst               = 1'b1;
        reg_wr                = 1'b0;
        reg_rd                = 1'b0;
        reg_addr              = 20'h0;
        reg_wdata             = 32'h0;
        vblank_start          = 1'b0;
        pipe_enabled          = 1'b1;
        tiled_surface         = 1'b0;
        src_key_enable        = 1'b0;
        dst_key_enable        = 1'b0;
        linear_surface_offset = 32'h0;
        sprite_pixel          = 24'h0;
        primary_pixel         = 24'h0;
        repeat (16) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        tick();
        t_regs();
        t_buf();
        t_keys();
        t_pan();
        summarize();
    end
endmodule : tb
